// File: rtl/tfa_defines.svh
// Register map, reset values and timing constants of the touch frame block
`ifndef TFA_DEFINES_SVH
`define TFA_DEFINES_SVH
`define TFA_A_STATUS 8'h10
`define TFA_A_POSX 8'h11
`define TFA_A_POSY 8'h12
`define TFA_A_POSLO 8'h13
`define TFA_A_SCAN 8'h22
`define TFA_A_THX 8'h23
`define TFA_A_THY 8'h24
`define TFA_A_FASTL 8'h25
`define TFA_A_FASTH 8'h26
`define TFA_A_SLOWL 8'h27
`define TFA_A_SLOWH 8'h28
`define TFA_A_TMO 8'h29
`define TFA_A_HYS 8'h2a
`define TFA_A_LIFT 8'h2b
`define TFA_A_PRESS 8'h2c
`define TFA_A_KIND 8'h31
`define TFA_A_LEVEL 8'h32
`define TFA_A_BIGL 8'h35
`define TFA_A_BIGH 8'h36
`define TFA_A_GAIN0 8'h50
`define TFA_R_SCAN 8'h06
`define TFA_R_THX 8'h37
`define TFA_R_THY 8'h28
`define TFA_R_HYS 8'h04
`define TFA_R_KIND 8'h02
`define TFA_R_LEVEL 8'h01
`define TFA_R_FAST 16'h0142
`define TFA_R_SLOW 16'h0c99
`define TFA_R_TMO 8'h20
`define TFA_R_DEB 8'h01
`define TFA_NCH 15
`define TFA_NX 9
`define TFA_HIST 9
`define TFA_UNITY 8'h40
`define TFA_UNIT_NS 31000
`define TFA_CLK_NS 20
`define TFA_UNIT_CYC (`TFA_UNIT_NS / `TFA_CLK_NS)
`define TFA_DEV_ADDR 7'h2a
`endif

// File: rtl/tfa_pkg.sv
// Types shared by the touch frame block
package tfa_pkg;
	typedef enum logic [1:0] {
		FR_ACQ = 2'b00,
		FR_DEC = 2'b01,
		FR_SLEEP = 2'b10
	} tfa_frame_type;
	typedef enum logic [2:0] {
		I2_IDLE = 3'b000,
		I2_ADDR = 3'b001,
		I2_AACK = 3'b010,
		I2_WR = 3'b011,
		I2_WACK = 3'b100,
		I2_RD = 3'b101,
		I2_RACK = 3'b110
	} tfa_i2c_type;
endpackage

// File: rtl/tfa_top.sv
// Touch frame acquisition, filtering, decode and I2C register slave
// Function
// - Frame runs acquire, decode, then sleep
// - Periods count 31 us units minus one
// - Four-bit frame counter in status nibble
// - Status bits for contact and gesture
// - Big contact bit two, bit three zero
// - Twelve-bit positions split high and nibbles
// - Sum repeated scans per channel, default six
// - Per-axis thresholds, defaults 55 and 40
// - Threshold_margin margin raises or lowers threshold
// - Kind zero passes values unfiltered
// - Kind one median over 3-9 samples
// - Kind two recursive weight 1/2,1/4,1/8
// - Kind three average over 2,4,8
// - Big contact when channel sum exceeds limit
// - Big contact never stops position decode
// - Limit zero skips big contact work
// - Gain coefficient scales, 64 means one
// - Zero coefficient leaves channel unscaled
`include "tfa_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module tfa_top
	import tfa_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// I2C pins, open drain
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_b,
	// Sensor front end
	output logic acq_req,
	output logic [3:0] acq_chan,
	input wire logic [9:0] acq_data,
	input wire logic acq_valid,
	// Gesture engine
	input wire logic gesture_pending
);
	localparam int NCH = `TFA_NCH;
	localparam int NH = `TFA_HIST;

	// Configuration registers
	logic [7:0] scan_q, thx_q, thy_q, hys_q, tmo_q, lift_q, press_q, kind_q, level_q;
	logic [15:0] fast_q, slow_q, big_lim_q;
	logic [7:0] gain_q [NCH];
	// Block state
	tfa_frame_type st_q;
	logic [3:0] ch_q, frame_q;
	logic [7:0] rep_q, deb_q, idle_q;
	logic [15:0] sum_q, ticks_q, big_sum_q, px_v_q, py_v_q;
	logic [15:0] hist_q [NCH][NH];
	logic [15:0] filt_q [NCH];
	logic [10:0] unit_q;
	logic [3:0] px_i_q, py_i_q;
	logic contact_q, hit_q, big_q, slow_mode_q;
	logic [11:0] pos_x_q, pos_y_q;
	logic [7:0] status_q;
	// I2C side
	logic [2:0] scl_s, sda_s;
	logic scl_f, sda_f, scl_p, sda_p;
	tfa_i2c_type i2_q;
	logic [2:0] bit_q;
	logic [7:0] shr_q, ptr_q, rsh_q;
	logic rw_q, first_q;
	logic addr_got_q;
	logic wr_en;
	logic [7:0] rd_data;

	// Pin filters: a level counts once stages two and three agree
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			scl_f <= 1'b1;
			sda_f <= 1'b1;
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_s <= {scl_s[1:0], scl_in};
			sda_s <= {sda_s[1:0], sda_in};
			if (scl_s[1] == scl_s[2]) scl_f <= scl_s[2];
			if (sda_s[1] == sda_s[2]) sda_f <= sda_s[2];
			scl_p <= scl_f;
			sda_p <= sda_f;
		end
	end

	wire scl_rise = scl_f & ~scl_p;
	wire scl_fall = ~scl_f & scl_p;
	wire i2_start = scl_f & scl_p & sda_p & ~sda_f;
	wire i2_stop = scl_f & scl_p & ~sda_p & sda_f;
	assign wr_en = scl_fall && i2_q == I2_WR && bit_q == 3'h0 && !first_q;

	// Read mux; status and position come from hardware state
	always_comb begin
		rd_data = 8'h00;
		unique case (ptr_q)
			`TFA_A_STATUS: rd_data = status_q;
			`TFA_A_POSX: rd_data = pos_x_q[11:4];
			`TFA_A_POSY: rd_data = pos_y_q[11:4];
			`TFA_A_POSLO: rd_data = {pos_x_q[3:0], pos_y_q[3:0]};
			`TFA_A_SCAN: rd_data = scan_q;
			`TFA_A_THX: rd_data = thx_q;
			`TFA_A_THY: rd_data = thy_q;
			`TFA_A_FASTL: rd_data = fast_q[7:0];
			`TFA_A_FASTH: rd_data = fast_q[15:8];
			`TFA_A_SLOWL: rd_data = slow_q[7:0];
			`TFA_A_SLOWH: rd_data = slow_q[15:8];
			`TFA_A_TMO: rd_data = tmo_q;
			`TFA_A_HYS: rd_data = hys_q;
			`TFA_A_LIFT: rd_data = lift_q;
			`TFA_A_PRESS: rd_data = press_q;
			`TFA_A_KIND: rd_data = kind_q;
			`TFA_A_LEVEL: rd_data = level_q;
			`TFA_A_BIGL: rd_data = big_lim_q[7:0];
			`TFA_A_BIGH: rd_data = big_lim_q[15:8];
			default: begin
				if (ptr_q >= `TFA_A_GAIN0 && ptr_q < `TFA_A_GAIN0 + 8'(NCH))
					rd_data = gain_q[4'(ptr_q - `TFA_A_GAIN0)];
			end
		endcase
	end

	// I2C slave: sample on SCL rise, drive on SCL fall; first write byte is the pointer
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			i2_q <= I2_IDLE;
			bit_q <= 3'h0;
			shr_q <= 8'h00;
			rsh_q <= 8'h00;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			first_q <= 1'b1;
			addr_got_q <= 1'b0;
			sda_oe_b <= 1'b1;
		end else if (i2_stop) begin
			i2_q <= I2_IDLE;
			sda_oe_b <= 1'b1;
		end else if (i2_start) begin
			i2_q <= I2_ADDR;
			bit_q <= 3'h0;
			first_q <= 1'b1;
			addr_got_q <= 1'b0; // The clock fall that ends a start carries no byte
			sda_oe_b <= 1'b1;
		end else if (scl_rise) begin
			if (i2_q == I2_ADDR || i2_q == I2_WR) begin
				if (i2_q == I2_ADDR) addr_got_q <= 1'b1;
				shr_q <= {shr_q[6:0], sda_f};
				bit_q <= bit_q + 3'h1;
			end else if (i2_q == I2_RD) begin
				bit_q <= bit_q + 3'h1;
			end else if (i2_q == I2_RACK && sda_f) begin
				i2_q <= I2_IDLE; // Master NACK ends the read
			end
		end else if (scl_fall) begin
			unique case (i2_q)
				I2_ADDR: if (bit_q == 3'h0 && addr_got_q) begin
					if (shr_q[7:1] == `TFA_DEV_ADDR) begin
						i2_q <= I2_AACK;
						rw_q <= shr_q[0];
						sda_oe_b <= 1'b0;
					end else i2_q <= I2_IDLE;
				end
				I2_AACK: begin
					if (rw_q) begin
						i2_q <= I2_RD;
						rsh_q <= {rd_data[6:0], 1'b0};
						sda_oe_b <= rd_data[7];
					end else begin
						i2_q <= I2_WR;
						sda_oe_b <= 1'b1;
					end
				end
				I2_WR: if (bit_q == 3'h0) begin
					i2_q <= I2_WACK;
					sda_oe_b <= 1'b0;
					first_q <= 1'b0;
					if (first_q) ptr_q <= shr_q;
					else ptr_q <= ptr_q + 8'h01;
				end
				I2_WACK: begin
					i2_q <= I2_WR;
					sda_oe_b <= 1'b1;
				end
				I2_RD: begin
					if (bit_q == 3'h0) begin
						i2_q <= I2_RACK;
						sda_oe_b <= 1'b1;
						ptr_q <= ptr_q + 8'h01;
					end else begin
						sda_oe_b <= rsh_q[7];
						rsh_q <= {rsh_q[6:0], 1'b0};
					end
				end
				I2_RACK: begin
					i2_q <= I2_RD;
					rsh_q <= {rd_data[6:0], 1'b0};
					sda_oe_b <= rd_data[7];
				end
				I2_IDLE: sda_oe_b <= 1'b1;
			endcase
		end
	end

	// Open drain: only ever pulls low
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) sda_out <= 1'b0;
		else sda_out <= 1'b0;
	end

	// Host-writable settings; a write lands on the ACK edge of its byte
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			scan_q <= `TFA_R_SCAN;
			thx_q <= `TFA_R_THX;
			thy_q <= `TFA_R_THY;
			hys_q <= `TFA_R_HYS;
			fast_q <= `TFA_R_FAST;
			slow_q <= `TFA_R_SLOW;
			tmo_q <= `TFA_R_TMO;
			lift_q <= `TFA_R_DEB;
			press_q <= `TFA_R_DEB;
			kind_q <= `TFA_R_KIND;
			level_q <= `TFA_R_LEVEL;
			big_lim_q <= 16'h0000;
			for (int i = 0; i < NCH; i++) gain_q[i] <= 8'h00;
		end else if (wr_en) begin
			unique case (ptr_q)
				`TFA_A_SCAN: scan_q <= shr_q;
				`TFA_A_THX: thx_q <= shr_q;
				`TFA_A_THY: thy_q <= shr_q;
				`TFA_A_FASTL: fast_q[7:0] <= shr_q;
				`TFA_A_FASTH: fast_q[15:8] <= shr_q;
				`TFA_A_SLOWL: slow_q[7:0] <= shr_q;
				`TFA_A_SLOWH: slow_q[15:8] <= shr_q;
				`TFA_A_TMO: tmo_q <= shr_q;
				`TFA_A_HYS: hys_q <= shr_q;
				`TFA_A_LIFT: lift_q <= shr_q;
				`TFA_A_PRESS: press_q <= shr_q;
				`TFA_A_KIND: kind_q <= shr_q;
				`TFA_A_LEVEL: level_q <= shr_q;
				`TFA_A_BIGL: big_lim_q[7:0] <= shr_q;
				`TFA_A_BIGH: big_lim_q[15:8] <= shr_q;
				default: begin
					if (ptr_q >= `TFA_A_GAIN0 && ptr_q < `TFA_A_GAIN0 + 8'(NCH))
						gain_q[4'(ptr_q - `TFA_A_GAIN0)] <= shr_q;
				end
			endcase
		end
	end

	// Channel filter on the newest scan sum
	logic [15:0] new_sum, filt_v, med_v;
	logic [15:0] win [NH];
	logic [19:0] acc;
	logic [3:0] wlen;
	logic [1:0] sh;
	logic signed [17:0] diff;
	logic last_rep;
	assign new_sum = sum_q + {6'h00, acq_data};
	assign last_rep = rep_q + 8'h01 >= scan_q; // Zero repeats acts as one
	always_comb begin
		int lt;
		lt = 0;
		acc = 20'h00000;
		med_v = new_sum;
		sh = (level_q[1:0] == 2'h0) ? 2'h1 : level_q[1:0];
		wlen = (level_q == 8'h5 || level_q == 8'h7 || level_q == 8'h9) ? level_q[3:0] : 4'h3;
		win[0] = new_sum;
		for (int j = 1; j < NH; j++) win[j] = hist_q[ch_q][j - 1];
		// Median by rank: the element with half the window below it
		for (int i = 0; i < NH; i++) begin
			lt = 0;
			for (int j = 0; j < NH; j++)
				if (j < wlen && (win[j] < win[i] || (win[j] == win[i] && j < i))) lt++;
			if (i < wlen && lt == wlen / 2) med_v = win[i];
		end
		for (int j = 0; j < 8; j++)
			if (j < (1 << sh)) acc = acc + {4'h0, win[j]};
		diff = $signed({2'b00, new_sum}) - $signed({2'b00, filt_q[ch_q]});
		unique case (kind_q)
			8'h01: filt_v = med_v;
			8'h02: filt_v = 16'(filt_q[ch_q] + 16'(diff >>> sh));
			8'h03: filt_v = 16'(acc >> sh);
			default: filt_v = new_sum;
		endcase
	end

	// Compensation and threshold of the channel under decode
	logic [23:0] prod;
	logic [15:0] comp_v, thr_v;
	logic [8:0] base_thr;
	assign prod = filt_q[ch_q] * gain_q[ch_q];
	// A zero coefficient bypasses the multiply result; prod is still formed
	assign comp_v = (gain_q[ch_q] == 8'h00) ? filt_q[ch_q] :
		((|prod[23:22]) ? 16'hffff : prod[21:6]);
	assign base_thr = {1'b0, (ch_q < 4'(`TFA_NX)) ? thx_q : thy_q};
	// Higher while released, lower while touched
	assign thr_v = contact_q ? ((base_thr > {1'b0, hys_q}) ? 16'(base_thr - {1'b0, hys_q}) : 16'h0000)
		: 16'(base_thr + {1'b0, hys_q});

	// 31 us unit ticker and frame period
	logic tick, frame_end;
	logic [15:0] period;
	assign tick = unit_q == 11'(`TFA_UNIT_CYC - 1);
	assign period = slow_mode_q ? slow_q : fast_q;
	assign frame_end = st_q == FR_SLEEP && ticks_q + 16'h0001 >= period;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			unit_q <= 11'h000;
			ticks_q <= 16'h0000;
		end else if (frame_end) begin
			unit_q <= 11'h000;
			ticks_q <= 16'h0000;
		end else begin
			unit_q <= tick ? 11'h000 : unit_q + 11'h001;
			if (tick && ticks_q != 16'hffff) ticks_q <= ticks_q + 16'h0001;
		end
	end

	// Frame sequencer: acquire every channel, decode, sleep
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= FR_ACQ;
			ch_q <= 4'h0;
			rep_q <= 8'h00;
			sum_q <= 16'h0000;
			acq_req <= 1'b0;
			acq_chan <= 4'h0;
			hit_q <= 1'b0;
			big_sum_q <= 16'h0000;
			px_v_q <= 16'h0000;
			py_v_q <= 16'h0000;
			px_i_q <= 4'h0;
			py_i_q <= 4'h0;
			for (int i = 0; i < NCH; i++) begin
				filt_q[i] <= 16'h0000;
				for (int j = 0; j < NH; j++) hist_q[i][j] <= 16'h0000;
			end
		end else begin
			unique case (st_q)
				FR_ACQ: begin
					acq_chan <= ch_q;
					acq_req <= !acq_valid;
					if (acq_valid) begin
						sum_q <= last_rep ? 16'h0000 : new_sum;
						rep_q <= last_rep ? 8'h00 : rep_q + 8'h01;
						if (last_rep) begin
							filt_q[ch_q] <= filt_v;
							hist_q[ch_q][0] <= new_sum;
							for (int j = 1; j < NH; j++) hist_q[ch_q][j] <= hist_q[ch_q][j - 1];
							ch_q <= (ch_q == 4'(NCH - 1)) ? 4'h0 : ch_q + 4'h1;
							if (ch_q == 4'(NCH - 1)) begin
								st_q <= FR_DEC;
								acq_req <= 1'b0;
								hit_q <= 1'b0;
								big_sum_q <= 16'h0000;
								px_v_q <= 16'h0000;
								py_v_q <= 16'h0000;
							end
						end
					end
				end
				FR_DEC: begin
					if (comp_v > thr_v) hit_q <= 1'b1;
					// Saturating sum; skipped when the limit is zero
					if (big_lim_q != 16'h0000)
						big_sum_q <= (17'(big_sum_q) + 17'(comp_v) > 17'h0ffff) ? 16'hffff : big_sum_q + comp_v;
					// Peak channel per axis gives the coarse position
					if (ch_q < 4'(`TFA_NX) && comp_v > px_v_q) begin
						px_v_q <= comp_v;
						px_i_q <= ch_q;
					end
					if (ch_q >= 4'(`TFA_NX) && comp_v > py_v_q) begin
						py_v_q <= comp_v;
						py_i_q <= ch_q - 4'(`TFA_NX);
					end
					ch_q <= (ch_q == 4'(NCH - 1)) ? 4'h0 : ch_q + 4'h1;
					if (ch_q == 4'(NCH - 1)) st_q <= FR_SLEEP;
				end
				FR_SLEEP: if (frame_end) st_q <= FR_ACQ;
				default: st_q <= FR_ACQ;
			endcase
		end
	end

	// Frame outcome: debounce, idle tracking, positions, big contact
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			contact_q <= 1'b0;
			deb_q <= 8'h00;
			idle_q <= 8'h00;
			slow_mode_q <= 1'b0;
			frame_q <= 4'h0;
			big_q <= 1'b0;
			pos_x_q <= 12'h000;
			pos_y_q <= 12'h000;
		end else if (frame_end) begin
			frame_q <= frame_q + 4'h1;
			if (hit_q == contact_q) deb_q <= 8'h00;
			else if (deb_q + 8'h01 >= (hit_q ? press_q : lift_q)) begin
				contact_q <= hit_q;
				deb_q <= 8'h00;
			end else deb_q <= deb_q + 8'h01;
			// Position keeps decoding even past the big contact limit
			if (hit_q) begin
				pos_x_q <= {px_i_q, 8'h00};
				pos_y_q <= {py_i_q, 8'h00};
			end
			big_q <= (big_lim_q != 16'h0000) && (big_sum_q > big_lim_q);
			if (hit_q) idle_q <= 8'h00;
			else if (idle_q != 8'hff) idle_q <= idle_q + 8'h01;
			slow_mode_q <= !hit_q && idle_q + 8'h01 >= tmo_q;
		end
	end

	// Status image read by the host
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) status_q <= 8'h00;
		else status_q <= {frame_q, 1'b0, big_q, gesture_pending, contact_q};
	end

	frame_order_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(st_q == FR_DEC && $past(st_q) != FR_DEC) |-> $past(st_q) == FR_ACQ)
		else $error("decode not entered from acquire");
	frame_count_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		frame_end |=> frame_q == $past(frame_q) + 4'h1)
		else $error("frame counter did not advance");
	status_bits_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		##1 status_q[1] == $past(gesture_pending) && status_q[0] == $past(contact_q))
		else $error("status flags mismatch");
	bit3_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		status_q[3] == 1'b0 ##2 status_q[2] == $past(big_q))
		else $error("status bit 3 or 2 wrong");
	acq_only_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		acq_req |-> st_q == FR_ACQ)
		else $error("request outside acquire");
	big_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(frame_end && big_lim_q == 16'h0000) |=> !big_q ##1 status_q[2] == 1'b0)
		else $error("big contact with zero limit");
	sleep_len_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(st_q == FR_SLEEP && $past(st_q) == FR_SLEEP && ticks_q + 16'h0001 < period) |=> st_q == FR_SLEEP)
		else $error("frame ended early");
	idle_reset_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(frame_end && hit_q) |=> idle_q == 8'h00 && !slow_mode_q)
		else $error("idle count not cleared");
	gain_bypass_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(st_q == FR_DEC && gain_q[ch_q] == 8'h00 && filt_q[ch_q] > thr_v) |=> hit_q)
		else $error("unscaled channel missed");
	press_cov: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(contact_q));
	slow_cov: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(slow_mode_q));
	big_cov: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(big_q));
endmodule
`default_nettype wire

// File: dv/tfa_host_model.sv
// Host side of the register bus: open-drain I2C master
`include "tfa_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module tfa_host_model (
	// Clock used for bit timing
	input wire logic core_clk,
	// Resolved data line
	input wire logic sda,
	// Lines the host drives
	output logic scl,
	output logic sda_oe_b,
	output logic nak_seen
);
	// Low phase of 11 cycles leaves margin over the device pin filter
	localparam int Q = 5;
	localparam int H = 6;
	initial begin
		scl = 1'b1;
		sda_oe_b = 1'b1;
		nak_seen = 1'b0;
	end
	// One clock pulse: data set after the fall, line read before the next fall
	task automatic bit_io(input logic o, output logic i);
		repeat (Q) @(posedge core_clk);
		sda_oe_b <= o;
		repeat (H) @(posedge core_clk);
		scl <= 1'b1;
		repeat (H) @(posedge core_clk);
		i = sda;
		scl <= 1'b0;
	endtask
	// Start or repeated start, data falls while the clock is high
	task automatic start();
		repeat (Q) @(posedge core_clk);
		sda_oe_b <= 1'b1;
		repeat (H) @(posedge core_clk);
		scl <= 1'b1;
		repeat (H) @(posedge core_clk);
		sda_oe_b <= 1'b0;
		repeat (H) @(posedge core_clk);
		scl <= 1'b0;
	endtask
	task automatic stop();
		repeat (Q) @(posedge core_clk);
		sda_oe_b <= 1'b0;
		repeat (H) @(posedge core_clk);
		scl <= 1'b1;
		repeat (H) @(posedge core_clk);
		sda_oe_b <= 1'b1;
		repeat (H) @(posedge core_clk);
	endtask
	// Byte out, then the device must pull the ninth bit low
	task automatic wbyte(input logic [7:0] o);
		logic a;
		logic d;
		for (int k = 7; k >= 0; k--)
			bit_io(o[k], d);
		bit_io(1'b1, a);
		if (a !== 1'b0)
			nak_seen <= 1'b1;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
		start();
		wbyte({`TFA_DEV_ADDR, 1'b0});
		wbyte(a);
		wbyte(v);
		stop();
	endtask
	// Pointer write, repeated start, one byte read and ended by a NACK
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
		logic n;
		start();
		wbyte({`TFA_DEV_ADDR, 1'b0});
		wbyte(a);
		start();
		wbyte({`TFA_DEV_ADDR, 1'b1});
		for (int k = 7; k >= 0; k--)
			bit_io(1'b1, v[k]);
		bit_io(1'b1, n);
		stop();
	endtask
endmodule
`default_nettype wire

// File: dv/tfa_top_tb.sv
// Self-checking bench of the touch frame block
`include "tfa_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module tfa_top_tb;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic gesture_pending = 1'b0;
	logic acq_valid = 1'b0;
	logic [9:0] acq_data = 10'h000;
	logic [9:0] amp [16];
	logic scl, host_oe_b, dev_out, dev_oe_b, acq_req, nak_seen;
	logic [3:0] acq_chan;
	logic [3:0] last_nib;
	wire sda;
	int fail_count = 0;
	int compares = 0;
	int frames = 0;
	int frame_len = 0;
	int frame_samples = 0;
	int samples = 0;
	int low_run = 0;
	int cyc = 0;
	int last_start = 0;
	// Pull-up on the shared data line
	assign sda = host_oe_b & (dev_oe_b | dev_out);
	always #10 core_clk = ~core_clk;
	tfa_top tfa_top_i (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(dev_out),
		.sda_oe_b(dev_oe_b),
		.acq_req(acq_req),
		.acq_chan(acq_chan),
		.acq_data(acq_data),
		.acq_valid(acq_valid),
		.gesture_pending(gesture_pending)
	);
	tfa_host_model tfa_host_model_i (
		.core_clk(core_clk),
		.sda(sda),
		.scl(scl),
		.sda_oe_b(host_oe_b),
		.nak_seen(nak_seen)
	);
	// Front end answers one cycle after a request; frame starts follow a long idle
	always @(posedge core_clk) begin
		acq_valid <= acq_req & ~acq_valid;
		acq_data <= (acq_req & ~acq_valid) ? amp[acq_chan] : ~acq_data;
		cyc <= cyc + 1;
		low_run <= acq_req ? 0 : low_run + 1;
		if (acq_valid)
			samples <= samples + 1;
		if (acq_req && low_run > 3) begin
			frames <= frames + 1;
			frame_len <= cyc - last_start;
			last_start <= cyc;
			frame_samples <= samples;
			samples <= 0;
		end
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_rng(input string what, input int lo, input int hi, input int got);
		compares++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	task automatic stop_test();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		tfa_host_model_i.reg_wr(a, v);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		tfa_host_model_i.reg_rd(a, v);
	endtask
	task automatic sync();
		logic [7:0] s;
		rd(`TFA_A_STATUS, s);
		last_nib = s[7:4];
	endtask
	// Polls status until the frame nibble moves; a frame outlasts one poll
	task automatic next_frame(output logic [7:0] s);
		rd(`TFA_A_STATUS, s);
		for (int i = 0; i < 20 && s[7:4] === last_nib; i++)
			rd(`TFA_A_STATUS, s);
		chk("frame count", {4'h0, last_nib + 4'h1}, {4'h0, s[7:4]});
		last_nib = s[7:4];
	endtask
	// Second frame after the change holds only new samples
	task automatic settle(input int ch, input logic [9:0] v, output logic [7:0] s);
		amp[ch] <= v;
		sync();
		next_frame(s);
		next_frame(s);
	endtask
	task automatic t_reset();
		logic [7:0] v;
		logic [7:0] addr [10] = '{`TFA_A_SCAN, `TFA_A_THX, `TFA_A_THY, `TFA_A_HYS, `TFA_A_KIND,
			`TFA_A_LEVEL, `TFA_A_BIGL, `TFA_A_BIGH, `TFA_A_POSLO, 8'h20};
		logic [7:0] exp [10] = '{8'h06, 8'h37, 8'h28, 8'h04, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 10; i++) begin
			rd(addr[i], v);
			chk("reset value", exp[i], v);
		end
		wr(`TFA_A_STATUS, 8'hff);
		rd(`TFA_A_STATUS, v);
		chk("status low bits", 8'h00, {4'h0, v[3:0]});
	endtask
	// High bytes first so no long interim period is ever live
	task automatic t_timing();
		wr(`TFA_A_TMO, 8'h02);
		wr(`TFA_A_FASTH, 8'h00);
		wr(`TFA_A_FASTL, 8'h02);
		wr(`TFA_A_SLOWH, 8'h00);
		wr(`TFA_A_SLOWL, 8'h03);
		repeat (5) @(frames);
		chk_rng("slow frame", 3100, 3104, frame_len);
		chk_rng("samples", 90, 90, frame_samples);
		amp[3] <= 10'h030;
		repeat (3) @(frames);
		chk_rng("fast frame", 1550, 1554, frame_len);
		wr(`TFA_A_TMO, 8'hff);
	endtask
	task automatic t_thresh();
		logic [7:0] s;
		wr(`TFA_A_SCAN, 8'h02);
		wr(`TFA_A_KIND, 8'h00);
		settle(3, 10'd0, s);
		settle(3, 10'd29, s);
		chk("x sum 58", 8'h00, {7'h0, s[0]});
		settle(3, 10'd30, s);
		chk("x sum 60", 8'h01, {7'h0, s[0]});
		rd(`TFA_A_POSX, s);
		chk("x high", 8'h30, s);
		rd(`TFA_A_POSLO, s);
		chk("x low", 8'h00, s & 8'hf0);
		settle(3, 10'd26, s);
		chk("held at 52", 8'h01, {7'h0, s[0]});
		settle(3, 10'd25, s);
		chk("released at 50", 8'h00, {7'h0, s[0]});
		settle(10, 10'd23, s);
		chk("y sum 46", 8'h01, {7'h0, s[0]});
	endtask
	task automatic t_comp_big();
		logic [7:0] s;
		settle(10, 10'd0, s);
		wr(`TFA_A_GAIN0 + 8'h03, 8'h80);
		settle(3, 10'd15, s);
		chk("gain two", 8'h01, {7'h0, s[0]});
		wr(`TFA_A_GAIN0 + 8'h03, 8'h00);
		settle(3, 10'd30, s);
		chk("gain zero", 8'h01, {7'h0, s[0]});
		settle(10, 10'd20, s);
		chk("limit off", 8'h01, {5'h0, s[2:0]});
		wr(`TFA_A_BIGL, 8'h63);
		settle(10, 10'd20, s);
		chk("sum above", 8'h05, {5'h0, s[2:0]});
		rd(`TFA_A_POSX, s);
		chk("x high kept", 8'h30, s);
		wr(`TFA_A_BIGL, 8'h64);
		settle(10, 10'd20, s);
		chk("sum equal", 8'h01, {5'h0, s[2:0]});
		wr(`TFA_A_BIGL, 8'h00);
		gesture_pending <= 1'b1;
		rd(`TFA_A_STATUS, s);
		chk("gesture", 8'h03, {5'h0, s[2:0]});
		gesture_pending <= 1'b0;
	endtask
	// Step of 100 against a threshold of 59; counts frames until contact
	task automatic t_filter(input logic [7:0] kind, input logic [7:0] level, input int exp);
		logic [7:0] s;
		int k;
		// Unfiltered zeros first so no filter state is left from the last run
		wr(`TFA_A_KIND, 8'h00);
		amp[3] <= 10'd0;
		sync();
		repeat (3) next_frame(s);
		wr(`TFA_A_KIND, kind);
		wr(`TFA_A_LEVEL, level);
		sync();
		next_frame(s);
		amp[3] <= 10'd100;
		next_frame(s);
		k = 0;
		do begin
			next_frame(s);
			k++;
		end while (s[0] !== 1'b1 && k < 8);
		chk_rng("frames to contact", exp, exp, k);
	endtask
	// Main sequence
	initial begin
		foreach (amp[i])
			amp[i] = 10'h000;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_reset();
		t_timing();
		t_thresh();
		t_comp_big();
		amp[10] <= 10'd0;
		wr(`TFA_A_SCAN, 8'h01);
		t_filter(8'h01, 8'h05, 3);
		t_filter(8'h02, 8'h02, 4);
		t_filter(8'h03, 8'h02, 3);
		chk("ack", 8'h00, {7'h0, nak_seen});
		stop_test();
	end
	// Roughly 60 frames of 1551 cycles plus bus traffic; the limit leaves margin
	initial begin
		#(20 * 200000);
		fail_count++;
		$display("mismatch watchdog expected finish seen timeout");
		stop_test();
	end
endmodule
`default_nettype wire
